/* hw/ebet_pkg.sv */
`default_nettype none
// ----------------------------------------
// Shared constants of the event timer
// ----------------------------------------
package ebet_pkg;
    // Register byte addresses
    localparam logic [15:0] EBET_SEL0_ADDR  = 16'hFF6A;
    localparam logic [15:0] EBET_MODE0_ADDR = 16'hFF6B;
    localparam logic [15:0] EBET_CNT0_ADDR  = 16'hFF6C;
    localparam logic [15:0] EBET_CMP0_ADDR  = 16'hFF6D;
    localparam logic [15:0] EBET_SEL1_ADDR  = 16'hFF8C;
    localparam logic [15:0] EBET_MODE1_ADDR = 16'hFF43;
    localparam logic [15:0] EBET_CNT1_ADDR  = 16'hFF8D;
    localparam logic [15:0] EBET_CMP1_ADDR  = 16'hFF8E;
    // Reset value of every register
    localparam logic [7:0]  EBET_RST_VAL    = 8'h00;
    // Mode control field positions
    localparam int          EBET_RUN_BIT    = 7;
    localparam int          EBET_PWM_BIT    = 6;
    localparam int          EBET_SET_BIT    = 3;
    localparam int          EBET_CLR_BIT    = 2;
    localparam int          EBET_LVL_BIT    = 1;
    localparam int          EBET_TOE_BIT    = 0;
    // Clock select field
    localparam int          EBET_SEL_W      = 3;
    localparam logic [2:0]  EBET_SEL_FALL   = 3'h0;
    localparam logic [2:0]  EBET_SEL_RISE   = 3'h1;
    localparam logic [2:0]  EBET_SEL_FULL   = 3'h2;
    // Prescaler width and divider masks for codes 3..7
    localparam int          EBET_PRE_W      = 13;
    localparam logic [4:0][12:0] EBET_MASK0 =
        {13'h1FFF, 13'h00FF, 13'h003F, 13'h0003, 13'h0001};
    localparam logic [4:0][12:0] EBET_MASK1 =
        {13'h0FFF, 13'h00FF, 13'h003F, 13'h000F, 13'h0001};
    // Counter end values
    localparam logic [7:0]  EBET_CNT_MAX    = 8'hFF;
endpackage
`default_nettype wire

/* hw/ebet_top.sv */
// Notes on behaviour
// - 8-bit read-only counter steps by one per selected count clock edge.
// - Counter clears on reset, on run cleared, and on match in clear mode.
// - Outside pwm mode a counter/compare match raises the match interrupt.
// - In pwm mode overflow activates the output, compare match deactivates it.
// - Compare register is byte wide, any value, resets to zero.
// - Clock select register holds a 3-bit field in bits 0-2, resets zero.
// - Instance 0 codes: fall, rise, clk, /2, /4, /64, /256, /8192.
// - Instance 1 codes: fall, rise, clk, /2, /16, /64, /256, /4096.
// - In programming mode instance 0 edges come from the flash mode pin.
// - Clock select accepts single-bit as well as whole-byte writes.
// - Mode bit 0 means clear and start on match, 1 means pwm.
// - Run bit 1 counts; 0 clears the counter and halts it.
`default_nettype none

// ----------------------------------------
// One timer channel
// ----------------------------------------
module ebet_chan #(
    parameter int INST = 0
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // CPU access
    input  wire logic [15:0] addr,
    input  wire logic        wr,
    input  wire logic        bit_wr,
    input  wire logic [2:0]  bit_idx,
    input  wire logic        bit_val,
    input  wire logic [7:0]  wdata,
    output logic             rd_hit,
    output logic [7:0]       rd_val,
    // Shared prescaler
    input  wire logic [12:0] pre_q,
    // Pins
    input  wire logic        event_input,
    input  wire logic        flash_mode_pin,
    input  wire logic        prog_mode,
    output logic             timer_output,
    output logic             match_interrupt
);
    import ebet_pkg::*;

    localparam logic [15:0] A_SEL  = (INST == 0) ? EBET_SEL0_ADDR : EBET_SEL1_ADDR;
    localparam logic [15:0] A_MODE = (INST == 0) ? EBET_MODE0_ADDR : EBET_MODE1_ADDR;
    localparam logic [15:0] A_CNT  = (INST == 0) ? EBET_CNT0_ADDR : EBET_CNT1_ADDR;
    localparam logic [15:0] A_CMP  = (INST == 0) ? EBET_CMP0_ADDR : EBET_CMP1_ADDR;
    localparam logic [4:0][12:0] MASK = (INST == 0) ? EBET_MASK0 : EBET_MASK1;

    logic [7:0] cnt_q, cnt_d, cmp_q, cmp_d;
    logic [2:0] sel_q, sel_d;
    logic       run_q, run_d, pwm_q, pwm_d, lvl_q, lvl_d, toe_q, toe_d;
    logic       tff_q, tff_d, pff_q, pff_d, out_q, out_d, irq_q, irq_d;
    logic       s1_q, s2_q, s3_q;
    logic       hit_sel, hit_mode, hit_cmp, mode_wr;
    logic [7:0] sel_w, mode_w;
    logic [12:0] mask;
    logic       clk_en, tick, match, ovf, ev_raw;

    // ----------------------------------------
    // Write merge for byte and single-bit writes
    // ----------------------------------------
    function automatic logic [7:0] merge(input logic [7:0] old, input logic hit);
        logic [7:0] r;
        r = old;
        if (hit && wr) begin
            r = wdata;
        end else if (hit && bit_wr) begin
            r[bit_idx] = bit_val;
        end
        return r;
    endfunction

    // Address decode
    assign hit_sel  = (addr == A_SEL);
    assign hit_mode = (addr == A_MODE);
    assign hit_cmp  = (addr == A_CMP);
    assign mode_wr  = hit_mode && (wr || bit_wr);
    assign sel_w    = merge({5'h00, sel_q}, hit_sel);
    assign mode_w   = merge({run_q, pwm_q, 4'h0, lvl_q, toe_q}, hit_mode);

    // ----------------------------------------
    // Count clock selection
    // ----------------------------------------
    // Flash pin replaces the event pin ahead of the synchroniser
    assign ev_raw = (INST == 0 && prog_mode) ? flash_mode_pin : event_input;

    // Three-stage chain: s1 feeds only s2, edges come from s2 and s3
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= ev_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Selector; prescaler taps fire once per divided period
    always_comb begin
        mask = 13'h0000;
        unique case (sel_q)
            EBET_SEL_FALL: clk_en = !s2_q && s3_q;
            EBET_SEL_RISE: clk_en = s2_q && !s3_q;
            EBET_SEL_FULL: clk_en = 1'b1;
            default: begin
                mask   = MASK[sel_q - 3'h3];
                clk_en = ((pre_q & mask) == mask);
            end
        endcase
    end

    assign tick  = run_q && clk_en;
    assign match = (cnt_q == cmp_q);
    assign ovf   = tick && (cnt_q == EBET_CNT_MAX);

    // ----------------------------------------
    // Next state of registers, counter and outputs
    // ----------------------------------------
    always_comb begin
        sel_d = sel_w[EBET_SEL_W-1:0];
        cmp_d = merge(cmp_q, hit_cmp);
        run_d = mode_w[EBET_RUN_BIT];
        pwm_d = mode_w[EBET_PWM_BIT];
        lvl_d = mode_w[EBET_LVL_BIT];
        toe_d = mode_w[EBET_TOE_BIT];
        // Counter: stopped means cleared; match clears only in clear mode
        if (!run_q) begin
            cnt_d = 8'h00;
        end else if (tick && !pwm_q && match) begin
            cnt_d = 8'h00;
        end else if (tick) begin
            cnt_d = cnt_q + 8'h01;
        end else begin
            cnt_d = cnt_q;
        end
        // One pulse per match, at the count edge that clears
        irq_d = tick && !pwm_q && match;
        // Pwm flop: overflow beats a same-cycle match; stop or clear mode forces it off
        pff_d = run_q && pwm_q && (ovf || (pff_q && !match));
        // Timer flop: direct set/reset, else toggle on match if enabled
        tff_d = tff_q;
        if (mode_wr && !pwm_q && mode_w[EBET_SET_BIT] && !mode_w[EBET_CLR_BIT]) begin
            tff_d = 1'b1;
        end else if (mode_wr && !pwm_q && mode_w[EBET_CLR_BIT] && !mode_w[EBET_SET_BIT]) begin
            tff_d = 1'b0;
        end else if (irq_d && lvl_q) begin
            tff_d = !tff_q;
        end
        // Pin level; in pwm mode the level bit selects active low
        out_d = toe_q && (pwm_q ? (pff_q ^ lvl_q) : tff_q);
    end

    // State registers, grouped by family; every one clears on reset
    always_ff @(posedge clk) begin
        if (rst) begin
            {cnt_q, cmp_q} <= {EBET_RST_VAL, EBET_RST_VAL};
            sel_q <= 3'h0;
            {run_q, pwm_q, lvl_q, toe_q, tff_q, pff_q, out_q, irq_q} <= 8'h00;
        end else begin
            {cnt_q, cmp_q, sel_q} <= {cnt_d, cmp_d, sel_d};
            {run_q, pwm_q, lvl_q, toe_q} <= {run_d, pwm_d, lvl_d, toe_d};
            {tff_q, pff_q, out_q, irq_q} <= {tff_d, pff_d, out_d, irq_d};
        end
    end

    assign timer_output    = out_q;
    assign match_interrupt = irq_q;

    // ----------------------------------------
    // Read-back; set/reset bits read as zero
    // ----------------------------------------
    always_comb begin
        rd_hit = 1'b1;
        if (hit_sel) begin
            rd_val = {5'h00, sel_q};
        end else if (hit_mode) begin
            rd_val = {run_q, pwm_q, 4'h0, lvl_q, toe_q};
        end else if (addr == A_CNT) begin
            rd_val = cnt_q;
        end else if (hit_cmp) begin
            rd_val = cmp_q;
        end else begin
            rd_hit = 1'b0;
            rd_val = 8'h00;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_cnt_step: assert property (
        tick && !(match && !pwm_q) |=> cnt_q == 8'($past(cnt_q) + 8'h01))
        else $error("counter did not step by one");
    chk_stop_clear: assert property (
        !run_q |=> cnt_q == 8'h00 ##1 (run_q || cnt_q == 8'h00))
        else $error("stopped counter not zero");
    chk_match_clear: assert property (
        tick && !pwm_q && match |=> cnt_q == 8'h00 && match_interrupt)
        else $error("match did not clear and interrupt");
    chk_irq_cause: assert property (
        match_interrupt |-> $past(tick && !pwm_q && match))
        else $error("interrupt without match");
    chk_pwm_rise: assert property (
        run_q && pwm_q && ovf |=> pff_q && cnt_q == 8'h00 ##1 (!toe_q || timer_output == !lvl_q))
        else $error("overflow did not activate pwm");
    chk_pwm_fall: assert property (
        run_q && pwm_q && match && !ovf |=> !pff_q)
        else $error("match did not end pwm pulse");
    chk_cmp_write: assert property (
        hit_cmp && wr |=> cmp_q == $past(wdata))
        else $error("compare write lost");
    chk_sel_field: assert property (
        hit_sel && wr |=> sel_q == $past(wdata[2:0]) && (!hit_sel || rd_val[7:3] == 5'h00))
        else $error("clock select field wrong");
    chk_edge_tick: assert property (
        run_q && sel_q == EBET_SEL_RISE && tick |=> !tick)
        else $error("edge enable longer than one cycle");
    chk_full_rate: assert property (
        run_q && sel_q == EBET_SEL_FULL && $past(run_q) && $past(sel_q) == EBET_SEL_FULL
        && !match |-> ##1 cnt_q != $past(cnt_q) || pwm_q || match)
        else $error("full rate not counting");

    cov_irq: cover property (match_interrupt ##[1:300] match_interrupt);
    cov_pwm: cover property (pff_q ##[1:600] !pff_q);
    cov_wrap: cover property (pwm_q && ovf);
endmodule

// ----------------------------------------
// Top: prescaler, two channels, read port
// ----------------------------------------
module ebet_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // CPU memory access
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_bit_wr,
    input  wire logic [2:0]  cpu_bit_idx,
    input  wire logic        cpu_bit_val,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_rd,
    output logic [7:0]       cpu_rdata,
    // Pins and mode
    input  wire logic        event_input_0,
    input  wire logic        event_input_1,
    input  wire logic        flash_mode_pin,
    input  wire logic        prog_mode,
    output logic             timer_output_0,
    output logic             timer_output_1,
    output logic             match_interrupt_0,
    output logic             match_interrupt_1
);
    import ebet_pkg::*;

    logic [12:0] pre_q, pre_d;
    logic [7:0]  rdata_q, rdata_d, rv0, rv1;
    logic        rh0, rh1;

    // Free-running prescaler shared by both channels
    always_comb begin
        pre_d = pre_q + 13'h0001;
    end

    // Read data is held until the next read; unmapped reads give zero
    always_comb begin
        rdata_d = rdata_q;
        if (cpu_rd) begin
            rdata_d = rh0 ? rv0 : (rh1 ? rv1 : 8'h00);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q   <= 13'h0000;
            rdata_q <= 8'h00;
        end else begin
            pre_q   <= pre_d;
            rdata_q <= rdata_d;
        end
    end

    assign cpu_rdata = rdata_q;

    // Both channels get the flash mode pin; channel 0 alone uses it
    ebet_chan #(.INST(0)) u_ch0 (
        .clk             (clk),
        .rst             (rst),
        .addr            (cpu_addr),
        .wr              (cpu_wr),
        .bit_wr          (cpu_bit_wr),
        .bit_idx         (cpu_bit_idx),
        .bit_val         (cpu_bit_val),
        .wdata           (cpu_wdata),
        .rd_hit          (rh0),
        .rd_val          (rv0),
        .pre_q           (pre_q),
        .event_input     (event_input_0),
        .flash_mode_pin  (flash_mode_pin),
        .prog_mode       (prog_mode),
        .timer_output    (timer_output_0),
        .match_interrupt (match_interrupt_0)
    );

    ebet_chan #(.INST(1)) u_ch1 (
        .clk             (clk),
        .rst             (rst),
        .addr            (cpu_addr),
        .wr              (cpu_wr),
        .bit_wr          (cpu_bit_wr),
        .bit_idx         (cpu_bit_idx),
        .bit_val         (cpu_bit_val),
        .wdata           (cpu_wdata),
        .rd_hit          (rh1),
        .rd_val          (rv1),
        .pre_q           (pre_q),
        .event_input     (event_input_1),
        .flash_mode_pin  (flash_mode_pin),
        .prog_mode       (prog_mode),
        .timer_output    (timer_output_1),
        .match_interrupt (match_interrupt_1)
    );
endmodule
`default_nettype wire

/* verification/ebet_pin_model.sv */
`default_nettype none
// ----------------------------------------
// Far-side pins: event sources and flash pin
// ----------------------------------------
module ebet_pin_model (
    // Clock
    input  wire logic clk,
    // Pin levels
    output logic      event_input_0,
    output logic      event_input_1,
    output logic      flash_mode_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // Lines idle low so selecting an edge never sees a false one
    initial begin
        event_input_0  = 1'b0;
        event_input_1  = 1'b0;
        flash_mode_pin = 1'b0;
    end

    // Each level is held 4 cycles, well past the two-flop synchroniser
    task automatic pulse(input int pin, input int n);
        for (int i = 0; i < 2 * n; i++) begin
            @(negedge clk);
            case (pin)
                0: event_input_0 = ~event_input_0;
                1: event_input_1 = ~event_input_1;
                default: flash_mode_pin = ~flash_mode_pin;
            endcase
            repeat (3) @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire

/* verification/test_eight_bit_event_timer.sv */
`default_nettype none
// ----------------------------------------
// Self-checking bench of the event timer
// ----------------------------------------
`define EBET_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

module test_eight_bit_event_timer;
    timeunit 1ns;
    timeprecision 1ns;
    import ebet_pkg::*;

    typedef struct packed { logic inst; logic [2:0] code; int span; logic [7:0] steps; } ebet_row_t;

    logic        clk, rst, cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd, prog_mode;
    logic [15:0] cpu_addr;
    logic [2:0]  cpu_bit_idx;
    logic [7:0]  cpu_wdata, cpu_rdata, c1, c2, c3;
    logic        ev0, ev1, flash, tout0, tout1, irq0, irq1;
    int          errors, comparisons, ni0, ni1, hi0, hi1;
    logic [15:0] a_sel [2] = '{EBET_SEL0_ADDR, EBET_SEL1_ADDR};
    logic [15:0] a_mode [2] = '{EBET_MODE0_ADDR, EBET_MODE1_ADDR};
    logic [15:0] a_cnt [2] = '{EBET_CNT0_ADDR, EBET_CNT1_ADDR};
    logic [15:0] a_cmp [2] = '{EBET_CMP0_ADDR, EBET_CMP1_ADDR};
    // Spans are three periods of each divided clock, so three steps are due
    ebet_row_t   rows [12] = '{'{0, 2, 3, 3}, '{0, 3, 6, 3}, '{0, 4, 12, 3}, '{0, 5, 192, 3},
                                '{0, 6, 768, 3}, '{0, 7, 24576, 3}, '{1, 2, 3, 3}, '{1, 3, 6, 3},
                                '{1, 4, 48, 3}, '{1, 5, 192, 3}, '{1, 6, 768, 3}, '{1, 7, 12288, 3}};

    // ----------------------------------------
    // Design, pins and clock
    // ----------------------------------------
    ebet_top uut (.clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_bit_wr(cpu_bit_wr),
        .cpu_bit_idx(cpu_bit_idx), .cpu_bit_val(cpu_bit_val), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata), .event_input_0(ev0), .event_input_1(ev1), .flash_mode_pin(flash),
        .prog_mode(prog_mode), .timer_output_0(tout0), .timer_output_1(tout1),
        .match_interrupt_0(irq0), .match_interrupt_1(irq1));
    ebet_pin_model pins (.clk(clk), .event_input_0(ev0), .event_input_1(ev1), .flash_mode_pin(flash));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // Bus tasks, entered and left at a falling edge
    // ----------------------------------------
    // Each access ends with an idle cycle, so a following strobe never restarts in the same step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpu_addr  = a;
        cpu_wdata = d;
        cpu_wr    = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic bw(input logic [15:0] a, input logic [2:0] idx, input logic v);
        cpu_addr    = a;
        cpu_bit_idx = idx;
        cpu_bit_val = v;
        cpu_bit_wr  = 1'b1;
        @(negedge clk);
        cpu_bit_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        cpu_addr = a;
        cpu_rd   = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        d      = cpu_rdata;
        @(negedge clk);
    endtask

    // Stop first: select and compare change only while halted
    task automatic setup(input int i, input logic [7:0] code, input logic [7:0] cmp, input logic [7:0] m);
        wr(a_mode[i], 8'h00);
        wr(a_sel[i], code);
        wr(a_cmp[i], cmp);
        wr(a_mode[i], m & 8'h7F);
        wr(a_mode[i], m);
    endtask

    // Counts interrupt pulses and high output cycles over n cycles
    task automatic window(input int n);
        ni0 = 0;
        ni1 = 0;
        hi0 = 0;
        hi1 = 0;
        repeat (n) begin
            @(negedge clk);
            ni0 += (irq0 === 1'b1);
            ni1 += (irq1 === 1'b1);
            hi0 += (tout0 === 1'b1);
            hi1 += (tout1 === 1'b1);
        end
    endtask

    task automatic conclude();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        conclude();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd, prog_mode} = 6'h20;
        cpu_addr    = 16'h0000;
        cpu_bit_idx = 3'h0;
        cpu_wdata   = 8'h00;
        errors      = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        // Reset values, then an unmapped place
        for (int i = 0; i < 2; i++) begin
            rd(a_sel[i], c1);
            `EBET_CHK(c1, 8'h00)
            rd(a_mode[i], c1);
            `EBET_CHK(c1, 8'h00)
            rd(a_cnt[i], c1);
            `EBET_CHK(c1, 8'h00)
            rd(a_cmp[i], c1);
            `EBET_CHK(c1, 8'h00)
        end
        rd(16'hFF00, c1);
        `EBET_CHK(c1, 8'h00)
        // Full and divided clocks, free-running so the counter never clears
        foreach (rows[r]) begin
            setup(rows[r].inst, {5'h00, rows[r].code}, 8'hFF, 8'hC0);
            rd(a_sel[rows[r].inst], c1);
            `EBET_CHK(c1, {5'h00, rows[r].code})
            repeat (4) @(negedge clk);
            rd(a_cnt[rows[r].inst], c1);
            // The read task already spends one idle cycle after its sample
            repeat (rows[r].span - 2) @(negedge clk);
            rd(a_cnt[rows[r].inst], c2);
            `EBET_CHK(8'(c2 - c1), rows[r].steps)
        end
        // Falling and rising event edges on both instances
        for (int i = 0; i < 2; i++) begin
            for (int k = 0; k < 2; k++) begin
                setup(i, 8'(k), 8'hFF, 8'hC0);
                rd(a_cnt[i], c1);
                pins.pulse(i, 5);
                repeat (4) @(negedge clk);
                rd(a_cnt[i], c2);
                `EBET_CHK(8'(c2 - c1), 8'h05)
            end
        end
        // Programming mode: the flash pin replaces the event input
        prog_mode = 1'b1;
        setup(0, EBET_SEL_RISE, 8'hFF, 8'hC0);
        rd(a_cnt[0], c1);
        pins.pulse(0, 3);
        repeat (4) @(negedge clk);
        rd(a_cnt[0], c2);
        `EBET_CHK(c2, c1)
        pins.pulse(2, 3);
        repeat (4) @(negedge clk);
        rd(a_cnt[0], c3);
        `EBET_CHK(8'(c3 - c2), 8'h03)
        prog_mode = 1'b0;
        // Single-bit writes into a stopped clock select
        setup(0, 8'h00, 8'h00, 8'h00);
        bw(a_sel[0], 3'h2, 1'b1);
        bw(a_sel[0], 3'h0, 1'b1);
        rd(a_sel[0], c1);
        `EBET_CHK(c1, 8'h05)
        bw(a_sel[0], 3'h2, 1'b0);
        rd(a_sel[0], c1);
        `EBET_CHK(c1, 8'h01)
        // Clear-and-start: one match every ten clocks, then stop clears
        for (int i = 0; i < 2; i++) begin
            setup(i, EBET_SEL_FULL, 8'h09, 8'h80);
            repeat (20) @(negedge clk);
            window(500);
            `EBET_CHK(i ? ni1 : ni0, 50)
            rd(a_cnt[i], c1);
            `EBET_CHK(c1 < 8'h0A, 1'b1)
            wr(a_mode[i], 8'h00);
            repeat (2) @(negedge clk);
            rd(a_cnt[i], c1);
            `EBET_CHK(c1, 8'h00)
        end
        // Pwm: pin active from the wrap through the matching count, 129 of 256 at 80;
        // then one rewrite while running, hundreds of count clocks after the last one
        for (int i = 0; i < 2; i++) begin
            setup(i, EBET_SEL_FULL, 8'h80, 8'hC1);
            rd(a_cmp[i], c1);
            `EBET_CHK(c1, 8'h80)
            repeat (300) @(negedge clk);
            window(512);
            `EBET_CHK(i ? hi1 : hi0, 258)
            `EBET_CHK(i ? ni1 : ni0, 0)
            wr(a_cmp[i], 8'h40);
            repeat (300) @(negedge clk);
            window(512);
            `EBET_CHK(i ? hi1 : hi0, 130)
        end
        conclude();
    end
endmodule
`undef EBET_CHK
`default_nettype wire
